// ### hdl/mbbs_pkg.sv
// shared constants and types for the memory board bus slave
package mbbs_pkg;
   localparam int ADDR_W = 27;
   localparam int LANE_W = 16;
   localparam int RAM_AW = 10;
   localparam int RAM_DEPTH = 1024;
   localparam int FLASH_AW = 10;
   localparam int FLASH_DEPTH = 1024;
   // address bit that selects the 8-bit flash port over the 32-bit ram port
   localparam int FLASH_SEL_BIT = 25;
   localparam int RAM_WORD_LSB = 2;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [3:0] RTC_FRAME_BITS = 4'h8;
   localparam logic [LANE_W-1:0] LANE_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_DATA,
      ST_ACK
   } mbbs_state_e;
endpackage : mbbs_pkg

// ### hdl/mbbs_mem.sv
// byte-writable memory with registered read data
`timescale 1ns/1ps
module mbbs_mem
   #(parameter int WIDTH = 32,
     parameter int DEPTH = 1024,
     parameter int AW = 10)
   (
   // clock
   input wire logic clk,
   // access
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH/8-1:0] wrEn,
   input wire logic [WIDTH-1:0] wrData,
   output logic [WIDTH-1:0] rdData
   );
   // one storage array and one read register per byte lane
   for (genvar g = 0; g < WIDTH/8; g++)
   begin : gLane
      logic [7:0] laneMem [DEPTH];
      always_ff @(posedge clk)
      begin
         if (wrEn[g])
         begin
            laneMem[addr] <= wrData[g*8 +: 8];
         end
         rdData[g*8 +: 8] <= laneMem[addr];
      end
   end
endmodule : mbbs_mem

// ### hdl/mbbs_bus_slave.sv
// memory board bus slave: strobe/acknowledge cycle, ram and flash ports, rtc byte link
`timescale 1ns/1ps
module mbbs_bus_slave
   import mbbs_pkg::*;
   (
   // clock and resets
   input wire logic clk,
   input wire logic rst_n,
   input wire logic boardReset,
   // processor cycle control
   input wire logic addressStrobeN,
   input wire logic cpuSpaceQualifierN,
   input wire logic readNotWrite,
   input wire logic operandLenBit0,
   input wire logic operandLenBit1,
   input wire logic [ADDR_W-1:0] cpuAddressBus,
   input wire logic flashProgramEnable,
   // data lanes
   input wire logic [LANE_W-1:0] lowerDataLaneIn,
   output logic [LANE_W-1:0] lowerDataLaneOut,
   output logic lowerDataLaneOe,
   input wire logic [LANE_W-1:0] upperDataLaneIn,
   output logic [LANE_W-1:0] upperDataLaneOut,
   output logic upperDataLaneOe,
   // acknowledges, open drain
   output logic transferAck0N,
   output logic transferAck0Oe,
   output logic transferAck1N,
   output logic transferAck1Oe,
   // rtc serial link
   input wire logic serialClkIn,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOe,
   output logic [7:0] rtcByte,
   output logic rtcByteValid
   );
   mbbs_state_e state_r, state_nxt;
   logic strobePrev_r, strobePrev_nxt, isFlash_r, isFlash_nxt, isRead_r, isRead_nxt, startCycle;
   logic [31:0] laneOut_r, laneOut_nxt;
   logic [1:0] laneOe_r, laneOe_nxt, ack_r, ack_nxt, ackN_r, ackN_nxt;
   logic [3:0] ramWe, laneSel;
   logic [0:0] flashWe;
   logic [31:0] ramRd;
   logic [7:0] flashRd;
   logic [2:0] opLen;
   logic [1:0] sizeCode;

   always_comb
   begin
      sizeCode = {operandLenBit1, operandLenBit0};
      case (sizeCode)
         SIZE_BYTE: opLen = 3'h1;
         SIZE_WORD: opLen = 3'h2;
         SIZE_THREE: opLen = 3'h3;
         default: opLen = 3'h4;
      endcase
   end

   // byte lanes from offset and length; lane 3 is the top byte
   for (genvar g = 0; g < 4; g++)
   begin : gSel
      assign laneSel[3-g] = (3'(g) >= {1'b0, cpuAddressBus[1:0]})
         && (3'(g) < 3'({1'b0, cpuAddressBus[1:0]} + opLen));
   end

   // cycle starts on the falling strobe
   assign startCycle = !addressStrobeN && strobePrev_r && cpuSpaceQualifierN;

   // flash accepts data only while programming is enabled
   assign ramWe = (state_r == ST_ACCESS && !isRead_r && !isFlash_r) ? laneSel : 4'h0;
   assign flashWe = state_r == ST_ACCESS && !isRead_r && isFlash_r && flashProgramEnable;

   mbbs_mem #(.WIDTH(32), .DEPTH(RAM_DEPTH), .AW(RAM_AW)) uRam (
      .clk(clk),
      .addr(cpuAddressBus[RAM_WORD_LSB +: RAM_AW]),
      .wrEn(ramWe),
      .wrData({upperDataLaneIn, lowerDataLaneIn}),
      .rdData(ramRd)
   );

   mbbs_mem #(.WIDTH(8), .DEPTH(FLASH_DEPTH), .AW(FLASH_AW)) uFlash (
      .clk(clk),
      .addr(cpuAddressBus[FLASH_AW-1:0]),
      .wrEn(flashWe),
      .wrData(upperDataLaneIn[15:8]),
      .rdData(flashRd)
   );

   // bus cycle sequencer; lane and ack bit 1 is upper / ack1
   always_comb
   begin
      state_nxt = state_r;
      strobePrev_nxt = addressStrobeN;
      isFlash_nxt = isFlash_r;
      isRead_nxt = isRead_r;
      laneOut_nxt = laneOut_r;
      laneOe_nxt = laneOe_r;
      ack_nxt = ack_r;
      case (state_r)
         ST_IDLE:
         begin
            if (startCycle)
            begin
               isFlash_nxt = cpuAddressBus[FLASH_SEL_BIT];
               isRead_nxt = readNotWrite;
               state_nxt = ST_ACCESS;
            end
         end
         ST_ACCESS: state_nxt = ST_DATA;
         ST_DATA:
         begin
            // read data placed on the lanes before any acknowledge
            if (isRead_r)
            begin
               // byte port answers on the top lane, copied below
               // long port answers on both lanes
               laneOut_nxt = isFlash_r ? {flashRd, flashRd, LANE_RST} : ramRd;
               laneOe_nxt = {1'b1, !isFlash_r};
            end
            state_nxt = ST_ACK;
         end
         ST_ACK:
         begin
            // acknowledge once data is driven or taken
            // ram is a 32-bit port, flash an 8-bit port
            ack_nxt = {!isFlash_r, 1'b1};
         end
         default: state_nxt = ST_IDLE;
      endcase
      // everything released as soon as the strobe negates
      if (addressStrobeN && state_r != ST_IDLE)
      begin
         state_nxt = ST_IDLE;
         laneOe_nxt = 2'h0;
         ack_nxt = 2'h0;
      end
      ackN_nxt = ~ack_nxt;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         strobePrev_r <= 1'b1;
         isFlash_r <= 1'b0;
         isRead_r <= 1'b1;
         laneOut_r <= {LANE_RST, LANE_RST};
         laneOe_r <= 2'h0;
         ack_r <= 2'h0;
         ackN_r <= 2'h3;
      end
      else if (boardReset)
      begin
         state_r <= ST_IDLE;
         strobePrev_r <= 1'b1;
         isFlash_r <= 1'b0;
         isRead_r <= 1'b1;
         laneOut_r <= {LANE_RST, LANE_RST};
         laneOe_r <= 2'h0;
         ack_r <= 2'h0;
         ackN_r <= 2'h3;
      end
      else
      begin
         state_r <= state_nxt;
         strobePrev_r <= strobePrev_nxt;
         isFlash_r <= isFlash_nxt;
         isRead_r <= isRead_nxt;
         laneOut_r <= laneOut_nxt;
         laneOe_r <= laneOe_nxt;
         ack_r <= ack_nxt;
         ackN_r <= ackN_nxt;
      end
   end

   // acknowledges are active low, driven only when asserted
   assign lowerDataLaneOut = laneOut_r[15:0];
   assign lowerDataLaneOe = laneOe_r[0];
   assign upperDataLaneOut = laneOut_r[31:16];
   assign upperDataLaneOe = laneOe_r[1];
   assign transferAck0N = ackN_r[0];
   assign transferAck0Oe = ack_r[0];
   assign transferAck1N = ackN_r[1];
   assign transferAck1Oe = ack_r[1];

   // rtc serial receiver
   logic sclPrev_r, sclPrev_nxt, sdaPrev_r, sdaPrev_nxt;
   logic active_r, active_nxt, ackOe_r, ackOe_nxt, byteValid_r, byteValid_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt, byte_r, byte_nxt;

   always_comb
   begin
      sclPrev_nxt = serialClkIn;
      sdaPrev_nxt = serialDataIn;
      active_nxt = active_r;
      ackOe_nxt = ackOe_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      byte_nxt = byte_r;
      byteValid_nxt = 1'b0;
      // data bits paced by the host serial clock; start and stop taken from data edges while it is high
      if (serialClkIn && sclPrev_r && sdaPrev_r && !serialDataIn && !ackOe_r)
      begin
         active_nxt = 1'b1;
         bitCnt_nxt = 4'h0;
      end
      else if (serialClkIn && sclPrev_r && !sdaPrev_r && serialDataIn)
      begin
         active_nxt = 1'b0;
         ackOe_nxt = 1'b0;
      end
      else if (active_r && serialClkIn && !sclPrev_r && bitCnt_r < RTC_FRAME_BITS)
      begin
         shift_nxt = {shift_r[6:0], serialDataIn};
         bitCnt_nxt = bitCnt_r + 4'h1;
      end
      else if (active_r && !serialClkIn && sclPrev_r && bitCnt_r == RTC_FRAME_BITS)
      begin
         // eight bits make a frame, then acknowledge it
         if (ackOe_r)
         begin
            ackOe_nxt = 1'b0;
            bitCnt_nxt = 4'h0;
         end
         else
         begin
            ackOe_nxt = 1'b1;
            byte_nxt = shift_r;
            byteValid_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         active_r <= 1'b0;
         ackOe_r <= 1'b0;
         bitCnt_r <= 4'h0;
         shift_r <= BYTE_RST;
         byte_r <= BYTE_RST;
         byteValid_r <= 1'b0;
      end
      else if (boardReset)
      begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         active_r <= 1'b0;
         ackOe_r <= 1'b0;
         bitCnt_r <= 4'h0;
         shift_r <= BYTE_RST;
         byte_r <= BYTE_RST;
         byteValid_r <= 1'b0;
      end
      else
      begin
         sclPrev_r <= sclPrev_nxt;
         sdaPrev_r <= sdaPrev_nxt;
         active_r <= active_nxt;
         ackOe_r <= ackOe_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         byte_r <= byte_nxt;
         byteValid_r <= byteValid_nxt;
      end
   end

   assign serialDataOut = 1'b0;
   assign serialDataOe = ackOe_r;
   assign rtcByte = byte_r;
   assign rtcByteValid = byteValid_r;
endmodule : mbbs_bus_slave

// ### tb/mbbs_bus_slave_props.sv
// assertion checker bound to the bus slave
`timescale 1ns/1ps
module mbbs_bus_slave_props
   import mbbs_pkg::*;
   (
   // clock and resets
   input wire logic clk,
   input wire logic rst_n,
   input wire logic boardReset,
   // cycle control
   input wire logic addressStrobeN,
   input wire logic cpuSpaceQualifierN,
   input wire logic readNotWrite,
   input wire logic [ADDR_W-1:0] cpuAddressBus,
   // responses
   input wire logic lowerDataLaneOe,
   input wire logic upperDataLaneOe,
   input wire logic transferAck0N,
   input wire logic transferAck0Oe,
   input wire logic transferAck1N,
   input wire logic transferAck1Oe
   );
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_ACK_POLARITY:
      assert property (transferAck0Oe != transferAck0N && transferAck1Oe != transferAck1N)
         else $error("ack level wrong");
   AST_CPU_SPACE_QUIET:
      assert property ($fell(addressStrobeN) && !cpuSpaceQualifierN
         |=> (!transferAck0Oe && !upperDataLaneOe)[*5]) else $error("cpu space answered");
   AST_ACK_DELAY:
      assert property ($fell(addressStrobeN) && cpuSpaceQualifierN && !boardReset
         |-> ##1 !transferAck0Oe[*3] ##1 transferAck0Oe) else $error("ack timing");
   AST_READ_DATA_FIRST:
      assert property ($rose(transferAck0Oe) && readNotWrite |-> $past(upperDataLaneOe))
         else $error("ack before data");
   AST_ACK_WIDTH:
      assert property ($rose(transferAck0Oe)
         |-> transferAck1Oe == !cpuAddressBus[FLASH_SEL_BIT]) else $error("ack width");
   AST_FLASH_LANE:
      assert property (transferAck0Oe && !transferAck1Oe |-> !lowerDataLaneOe)
         else $error("byte transfer on lower lane");
   AST_ACK_HOLD:
      assert property (transferAck0Oe && !addressStrobeN && !boardReset |=> transferAck0Oe)
         else $error("ack dropped early");
   AST_ACK_RELEASE:
      assert property (transferAck0Oe && addressStrobeN && !boardReset
         |=> !transferAck0Oe && !upperDataLaneOe) else $error("ack not released");
   AST_BOARD_RESET:
      assert property (boardReset |=> !transferAck0Oe && !upperDataLaneOe)
         else $error("board reset ignored");
endmodule : mbbs_bus_slave_props

bind mbbs_bus_slave mbbs_bus_slave_props u_props (.clk(clk), .rst_n(rst_n),
   .boardReset(boardReset), .addressStrobeN(addressStrobeN),
   .cpuSpaceQualifierN(cpuSpaceQualifierN), .readNotWrite(readNotWrite),
   .cpuAddressBus(cpuAddressBus), .lowerDataLaneOe(lowerDataLaneOe),
   .upperDataLaneOe(upperDataLaneOe), .transferAck0N(transferAck0N),
   .transferAck0Oe(transferAck0Oe), .transferAck1N(transferAck1N),
   .transferAck1Oe(transferAck1Oe));

// ### tb/mbbs_rtc_host.sv
// serial host model that sends rtc byte frames
`timescale 1ns/1ps
module mbbs_rtc_host
   (
   // clock
   input wire logic clk,
   // frame request
   input wire logic sendGo,
   input wire logic [7:0] sendByte,
   // serial link
   output logic serialClk,
   output logic hostData,
   input wire logic lineData,
   output logic ackSeen
   );
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : hold
   task automatic bit_out(input logic d);
      serialClk = 1'b0;
      hold(2);
      hostData = d;
      hold(2);
      serialClk = 1'b1;
      hold(4);
   endtask : bit_out
   initial
   begin
      serialClk = 1'b1;
      hostData = 1'b1;
      ackSeen = 1'b0;
      forever
      begin
         @(posedge clk);
         if (sendGo)
         begin
            #2;
            hostData = 1'b0;
            hold(4);
            for (int i = 7; i >= 0; i--)
               bit_out(sendByte[i]);
            bit_out(1'b1);
            ackSeen = !lineData;
            serialClk = 1'b0;
            hold(2);
            hostData = 1'b0;
            hold(2);
            serialClk = 1'b1;
            hold(2);
            hostData = 1'b1;
         end
      end
   end
endmodule : mbbs_rtc_host

// ### tb/mbbs_bus_slave_test.sv
// self-checking bench for the bus slave
`timescale 1ns/1ps
module mbbs_bus_slave_test
   import mbbs_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic bRst = 1'b0;
   logic strb = 1'b1;
   logic qual = 1'b1;
   logic rnw = 1'b1;
   logic fen = 1'b0;
   logic go = 1'b0;
   logic [1:0] len = SIZE_LONG;
   logic [ADDR_W-1:0] addr = '0;
   logic [LANE_W-1:0] lo = '0;
   logic [LANE_W-1:0] up = '0;
   logic [7:0] goByte = 8'h00;
   logic [LANE_W-1:0] loOut, upOut;
   logic [7:0] rtcByte;
   logic loOe, upOe, a0n, a0oe, a1n, a1oe, sdo, sdoe, rtcValid, sclk, hData, ackSeen;
   wire logic sda = hData & ~(sdoe & ~sdo);
   wire logic [LANE_W-1:0] loIn = loOe ? loOut : lo;
   wire logic [LANE_W-1:0] upIn = upOe ? upOut : up;
   int n_fail = 0;
   int n_tests = 0;
   always #10 clk = ~clk;
   mbbs_bus_slave u_dut
   (
      .clk(clk), .rst_n(rst_n), .boardReset(bRst), .addressStrobeN(strb),
      .cpuSpaceQualifierN(qual), .readNotWrite(rnw), .operandLenBit0(len[0]),
      .operandLenBit1(len[1]), .cpuAddressBus(addr), .flashProgramEnable(fen),
      .lowerDataLaneIn(loIn), .lowerDataLaneOut(loOut), .lowerDataLaneOe(loOe),
      .upperDataLaneIn(upIn), .upperDataLaneOut(upOut), .upperDataLaneOe(upOe),
      .transferAck0N(a0n), .transferAck0Oe(a0oe), .transferAck1N(a1n),
      .transferAck1Oe(a1oe), .serialClkIn(sclk), .serialDataIn(sda),
      .serialDataOut(sdo), .serialDataOe(sdoe), .rtcByte(rtcByte), .rtcByteValid(rtcValid)
   );
   mbbs_rtc_host u_host
   (
      .clk(clk), .sendGo(go), .sendByte(goByte), .serialClk(sclk),
      .hostData(hData), .lineData(sda), .ackSeen(ackSeen)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic cyc(input logic rw, input logic [1:0] sz, input logic [ADDR_W-1:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic k);
      int n;
      n = 0;
      rnw = rw;
      len = sz;
      addr = a;
      {up, lo} = wd;
      strb = 1'b0;
      while (a0oe !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      chk("ack", 32'h1, {31'h0, a0oe});
      chk("ack0 level", 32'h0, {31'h0, a0n});
      rd = {upOut, loOut};
      k = a1oe;
      tick(1);
      strb = 1'b1;
      {up, lo} = ~wd;
      tick(2);
   endtask : cyc
   task automatic t_ram();
      logic [31:0] rd;
      logic k;
      logic [1:0] sz[5] = '{SIZE_BYTE, SIZE_WORD, SIZE_THREE, SIZE_LONG, SIZE_THREE};
      logic [1:0] of[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
      logic [31:0] ex[5] = '{32'h11bb3344, 32'h1122ccdd, 32'h112233dd, 32'haabbccdd,
         32'haabbcc44};
      cyc(1'b0, SIZE_LONG, 27'h40, 32'h12345678, rd, k);
      chk("ram ack1", 32'h1, {31'h0, k});
      cyc(1'b1, SIZE_LONG, 27'h40, 32'h0, rd, k);
      chk("ram read", 32'h12345678, rd);
      for (int i = 0; i < 5; i++)
      begin
         cyc(1'b0, SIZE_LONG, 27'h44, 32'h11223344, rd, k);
         cyc(1'b0, sz[i], {25'h11, of[i]}, 32'haabbccdd, rd, k);
         cyc(1'b1, SIZE_LONG, 27'h44, 32'h0, rd, k);
         chk("ram merge", ex[i], rd);
      end
   endtask : t_ram
   task automatic t_flash();
      logic [31:0] rd;
      logic k;
      fen = 1'b1;
      cyc(1'b0, SIZE_BYTE, 27'h2000003, 32'h5a000000, rd, k);
      chk("flash ack1", 32'h0, {31'h0, k});
      fen = 1'b0;
      cyc(1'b0, SIZE_BYTE, 27'h2000003, 32'h77000000, rd, k);
      cyc(1'b1, SIZE_BYTE, 27'h2000003, 32'h0, rd, k);
      chk("flash read", 32'h5a5a, {16'h0, rd[31:16]});
   endtask : t_flash
   task automatic t_spaces();
      qual = 1'b0;
      strb = 1'b0;
      tick(8);
      chk("cpu space", 32'h0, {30'h0, a0oe, upOe});
      strb = 1'b1;
      qual = 1'b1;
      tick(2);
      rnw = 1'b1;
      addr = 27'h40;
      len = SIZE_LONG;
      strb = 1'b0;
      tick(6);
      chk("ack held", 32'h1, {31'h0, a0oe});
      bRst = 1'b1;
      tick(1);
      chk("board reset", 32'h0, {30'h0, a0oe, upOe});
      strb = 1'b1;
      tick(1);
      bRst = 1'b0;
      tick(2);
   endtask : t_spaces
   task automatic t_rtc();
      int n;
      goByte = 8'ha5;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (n = 0; n < 400 && rtcValid !== 1'b1; n++)
         tick(1);
      chk("rtc valid", 32'h1, {31'h0, rtcValid});
      chk("rtc byte", 32'ha5, {24'h0, rtcByte});
      tick(100);
      chk("rtc ack", 32'h1, {31'h0, ackSeen});
   endtask : t_rtc
   task automatic complete_run();
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      tick(20);
      rst_n = 1'b1;
      tick(2);
      t_ram();
      t_flash();
      t_spaces();
      t_rtc();
      complete_run();
   end
   initial
   begin
      tick(20000);
      n_fail++;
      complete_run();
   end
endmodule : mbbs_bus_slave_test
